// ### bench/vec_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// fetch memory; waits 0..3 cycles, chosen by address bits, before answering
module vec_mem_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] key,
	output logic mem_rvalid,
	output logic [15:0] mem_rdata
);
	logic [1:0] cnt;
	logic go;
	assign go = mem_req && !mem_rvalid && cnt >= mem_addr[2:1];
	// word is address xor key; idle data inverts itself every cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt <= 2'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 16'h0;
		end else begin
			cnt <= (mem_req && !mem_rvalid) ? cnt + 2'h1 : 2'h0;
			mem_rvalid <= go;
			mem_rdata <= go ? mem_addr ^ key : ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

// ### bench/vector_table_interrupt_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vector_table_interrupt_map_tb;
	import vector_map_pkg::*;
	logic clk_sys, rst, gie, mem_rvalid, mem_req, irq_req, nmi_req;
	logic vacant_access_flag, debug_mailbox_in_flag, debug_mailbox_out_flag;
	logic correctable_bit_error_flag, uncorrectable_bit_error_flag;
	logic external_nmi_flag, oscillator_fault_flag, interval_timer_flag;
	logic wdt_interval_mode, sa0_async_mode, pc_load_valid, startup_done;
	logic boot_pw_enabled;
	logic [RST_SRC-1:0] reset_cause_flags;
	logic [SNMI_SRC-1:0] sys_nmi_enable;
	logic [UNMI_SRC-1:0] user_nmi_enable;
	logic [CMP_SRC-1:0] cmp_flags;
	logic [TB0_SRC-1:0] tb0_flags;
	logic [SA0_SRC-1:0] sa0_flags;
	logic [SB0_SRC-1:0] sb0_flags;
	logic [CONV_SRC-1:0] conv_flags;
	logic [TA0_SRC-1:0] ta0_flags;
	logic [NUM_VEC-1:0] maskable_enable;
	logic [SIG_WORDS*16-1:0] signatures;
	logic [4:0] debug_pw_words;
	logic [1:0] sb0_mode;
	logic [15:0] key, mem_rdata, mem_addr, pc_load, irq_vec_addr;
	logic [15:0] reset_cause_vector_reg, system_nmi_vector_reg;
	logic [15:0] user_nmi_vector_reg, comparator_vector_reg;
	logic [15:0] timer_b0_vector_reg, serial_a0_vector_reg;
	logic [15:0] serial_b0_vector_reg, converter_vector_reg, timer_a0_vector_reg;
	int fail_count = 0;
	int total_checks = 0;
	vector_table_interrupt_map u_dut (.*);
	vec_mem_model u_mem (.*);
	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// cycle ceiling against a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		test_done();
	end
	task automatic cmp(input string n, input logic [15:0] e, g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic t_boot(input logic [15:0] k);
		rst = 1'b1;
		key = k;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		for (int n = 0; n < 99 && startup_done !== 1'b1; n++) @(negedge clk_sys);
		cmp("pc", 16'hfffe ^ k, pc_load);
		cmp("sig0", 16'hff80 ^ k, signatures[15:0]);
		cmp("sig2", 16'hff84 ^ k, signatures[47:32]);
		cmp("sig5", 16'hff8a ^ k, signatures[95:80]);
		cmp("bootpw", 16'((16'hff84 ^ k) == ENABLED_SIG), 16'(boot_pw_enabled));
		cmp("dbglen", (16'hff82 ^ k) & 16'h1f, 16'(debug_pw_words));
		$display("boot test done");
	endtask
	task automatic t_nmi();
		{vacant_access_flag, sys_nmi_enable, reset_cause_flags} = 16'h8418;
		repeat (2) @(negedge clk_sys);
		cmp("snmi", 16'h1, 16'(nmi_req));
		cmp("snmivec", SYS_NMI_VEC_ADDR, irq_vec_addr);
		cmp("snmiiv", 16'h2, system_nmi_vector_reg);
		cmp("rstiv", 16'h8, reset_cause_vector_reg);
		{sys_nmi_enable, oscillator_fault_flag, user_nmi_enable} = 8'h07;
		repeat (2) @(negedge clk_sys);
		cmp("unmivec", USER_NMI_VEC_ADDR, irq_vec_addr);
		cmp("unmiiv", 16'h4, user_nmi_vector_reg);
		{user_nmi_enable, reset_cause_flags} = '0;
		repeat (2) @(negedge clk_sys);
		cmp("nmioff", 16'h0, 16'(nmi_req));
		$display("nmi test done");
	endtask
	task automatic t_mask();
		logic [15:0] v [9] = '{CMP_VEC_ADDR, TB0_CC0_VEC_ADDR, TB0_VEC_ADDR,
			WDT_VEC_ADDR, SA0_VEC_ADDR, SB0_VEC_ADDR, CONV_VEC_ADDR,
			TA0_CC0_VEC_ADDR, TA0_VEC_ADDR};
		{gie, wdt_interval_mode, sa0_async_mode} = 3'h7;
		sb0_mode = SB0_MODE_TWO_WIRE;
		{cmp_flags, tb0_flags, interval_timer_flag} = {2'h1, 7'h03, 1'b1};
		{sa0_flags, sb0_flags, ta0_flags} = {4'h4, 14'h0020, 3'h3};
		conv_flags = 38'h2000000000;
		// mask sources one by one from the top of the table
		for (int i = 0; i < 10; i++) begin
			maskable_enable = 11'h7ff << i;
			repeat (2) @(negedge clk_sys);
			cmp("irq", 16'(i < 9), 16'(irq_req));
			if (i < 9)
				cmp("ivec", v[i], irq_vec_addr);
		end
		cmp("conviv", 16'h004c, converter_vector_reg);
		cmp("cmpiv", 16'h0002, comparator_vector_reg);
		cmp("timer_b0_vector_reg", 16'h0002, timer_b0_vector_reg);
		cmp("sa0iv", 16'h0006, serial_a0_vector_reg);
		cmp("sb0iv", 16'h000c, serial_b0_vector_reg);
		cmp("timer_a0_vector_reg", 16'h0002, timer_a0_vector_reg);
		{maskable_enable, wdt_interval_mode, sa0_async_mode} = {11'h038, 2'h0};
		sb0_mode = 2'h0;
		repeat (2) @(negedge clk_sys);
		cmp("gated", 16'h0, 16'(irq_req));
		cmp("sa0sync", 16'h0000, serial_a0_vector_reg);
		cmp("sb0other", 16'h0000, serial_b0_vector_reg);
		{maskable_enable, gie} = {11'h7ff, 1'b0};
		repeat (2) @(negedge clk_sys);
		cmp("gieoff", 16'h0, 16'(irq_req));
		gie = 1'b1;
		$display("mask test done");
	endtask
	initial begin
		{gie, key, vacant_access_flag, debug_mailbox_in_flag,
			debug_mailbox_out_flag, correctable_bit_error_flag,
			uncorrectable_bit_error_flag, external_nmi_flag, oscillator_fault_flag,
			interval_timer_flag, wdt_interval_mode, sa0_async_mode, sb0_mode,
			reset_cause_flags, sys_nmi_enable, user_nmi_enable, cmp_flags,
			tb0_flags, sa0_flags, sb0_flags, conv_flags, ta0_flags,
			maskable_enable} = '0;
		rst = 1'b1;
		t_boot(16'h552e);
		t_nmi();
		t_mask();
		t_boot(16'h0000);
		test_done();
	end
endmodule
`default_nettype wire

// ### bench/vtim_sva.sv
`timescale 1ns/1ps
`default_nettype none
// fetch order, start-up results and nmi routing
module vtim_sva
	import vector_map_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic mem_rvalid,
	input wire logic pc_load_valid,
	input wire logic startup_done,
	input wire logic boot_pw_enabled,
	input wire logic irq_req,
	input wire logic nmi_req,
	input wire logic vacant_access_flag,
	input wire logic [SNMI_SRC-1:0] sys_nmi_enable,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_rdata,
	input wire logic [15:0] pc_load,
	input wire logic [15:0] irq_vec_addr,
	input wire logic [SIG_WORDS*16-1:0] signatures,
	input wire logic [4:0] debug_pw_words
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	pc_fetch_a: assert property (mem_req && mem_rvalid &&
		mem_addr == RESET_VEC_ADDR |=> pc_load_valid &&
		pc_load == $past(mem_rdata)) else $error("pc load wrong");
	pc_pulse_a: assert property (pc_load_valid |=>
		!pc_load_valid) else $error("pc load pulse too long");
	sig_step_a: assert property (mem_req && mem_rvalid &&
		mem_addr >= SIG_BASE_ADDR && mem_addr < 16'hff8a |=> mem_req &&
		mem_addr == $past(mem_addr) + 16'h2) else $error("signature order");
	sig_end_a: assert property (mem_req && mem_rvalid &&
		mem_addr == 16'hff8a |=> mem_addr == RESET_VEC_ADDR)
		else $error("reset word not next");
	boot_pw_a: assert property (startup_done |->
		boot_pw_enabled == (signatures[47:32] == ENABLED_SIG))
		else $error("password enable wrong");
	dbg_len_a: assert property (startup_done |->
		debug_pw_words == signatures[20:16]) else $error("debug length");
	early_irq_a: assert property (!startup_done |->
		!irq_req && !nmi_req) else $error("request before start-up");
	sys_nmi_a: assert property (startup_done && vacant_access_flag &&
		sys_nmi_enable[0] |=> nmi_req && irq_vec_addr == SYS_NMI_VEC_ADDR)
		else $error("system nmi missed");
endmodule
bind vector_table_interrupt_map vtim_sva u_sva (
	.clk_sys(clk_sys),
	.rst(rst),
	.mem_req(mem_req),
	.mem_rvalid(mem_rvalid),
	.pc_load_valid(pc_load_valid),
	.startup_done(startup_done),
	.boot_pw_enabled(boot_pw_enabled),
	.irq_req(irq_req),
	.nmi_req(nmi_req),
	.vacant_access_flag(vacant_access_flag),
	.sys_nmi_enable(sys_nmi_enable),
	.mem_addr(mem_addr),
	.mem_rdata(mem_rdata),
	.pc_load(pc_load),
	.irq_vec_addr(irq_vec_addr),
	.signatures(signatures),
	.debug_pw_words(debug_pw_words)
);
`default_nettype wire

// ### hdl/flag_vector_gen.sv
`timescale 1ns/1ps
`default_nettype none
module flag_vector_gen
	import vector_map_pkg::*;
#(
	parameter int unsigned N = 4
) (
	flags,
	code
);
	input wire logic [N-1:0] flags;
	output logic [15:0] code;
	// ---------------------------------------------------------------
	// lowest index wins; code is 2*(index+1), zero when idle
	// ---------------------------------------------------------------
	always_comb begin
		code = 16'h0000;
		for (int i = N - 1; i >= 0; i--) begin
			if (flags[i]) begin
				code = 16'((i + 1) * 2);
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/vector_map_pkg.sv
package vector_map_pkg;
	// ---------------------------------------------------------------
	// vector region addresses
	// ---------------------------------------------------------------
	localparam logic [15:0] RESET_VEC_ADDR = 16'hfffe;
	localparam logic [15:0] SYS_NMI_VEC_ADDR = 16'hfffc;
	localparam logic [15:0] USER_NMI_VEC_ADDR = 16'hfffa;
	localparam logic [15:0] CMP_VEC_ADDR = 16'hfff8;
	localparam logic [15:0] TB0_CC0_VEC_ADDR = 16'hfff6;
	localparam logic [15:0] TB0_VEC_ADDR = 16'hfff4;
	localparam logic [15:0] WDT_VEC_ADDR = 16'hfff2;
	localparam logic [15:0] SA0_VEC_ADDR = 16'hfff0;
	localparam logic [15:0] SB0_VEC_ADDR = 16'hffee;
	localparam logic [15:0] CONV_VEC_ADDR = 16'hffec;
	localparam logic [15:0] TA0_CC0_VEC_ADDR = 16'hffea;
	localparam logic [15:0] TA0_VEC_ADDR = 16'hffe8;
	localparam logic [15:0] BOOT_PW_LOW_ADDR = 16'hffe0;
	localparam logic [15:0] DEBUG_PW_BASE_ADDR = 16'hff88;
	localparam logic [15:0] SIG_BASE_ADDR = 16'hff80;
	localparam int unsigned SIG_WORDS = 6;
	localparam int unsigned BOOT_PW_WORDS = 16;
	// ---------------------------------------------------------------
	// group sizes, serial b0 mode and enabled signature
	// ---------------------------------------------------------------
	localparam int unsigned NUM_VEC = 11;
	localparam int unsigned RST_SRC = 10;
	localparam int unsigned SNMI_SRC = 5;
	localparam int unsigned UNMI_SRC = 2;
	localparam int unsigned SA0_SRC = 4;
	localparam int unsigned SB0_SRC = 14;
	localparam int unsigned CONV_SRC = 38;
	localparam int unsigned TB0_SRC = 7;
	localparam int unsigned TA0_SRC = 3;
	localparam int unsigned CMP_SRC = 2;
	localparam logic [1:0] SB0_MODE_TWO_WIRE = 2'h1;
	localparam logic [15:0] ENABLED_SIG = 16'haaaa;
endpackage

// ### hdl/vector_table_interrupt_map.sv
`timescale 1ns/1ps
`default_nettype none
module vector_table_interrupt_map
	import vector_map_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [RST_SRC-1:0] reset_cause_flags,
	input wire logic vacant_access_flag,
	input wire logic debug_mailbox_in_flag,
	input wire logic debug_mailbox_out_flag,
	input wire logic correctable_bit_error_flag,
	input wire logic uncorrectable_bit_error_flag,
	input wire logic [SNMI_SRC-1:0] sys_nmi_enable,
	input wire logic external_nmi_flag,
	input wire logic oscillator_fault_flag,
	input wire logic [UNMI_SRC-1:0] user_nmi_enable,
	input wire logic gie,
	input wire logic [CMP_SRC-1:0] cmp_flags,
	input wire logic [TB0_SRC-1:0] tb0_flags,
	input wire logic interval_timer_flag,
	input wire logic wdt_interval_mode,
	input wire logic sa0_async_mode,
	input wire logic [SA0_SRC-1:0] sa0_flags,
	input wire logic [1:0] sb0_mode,
	input wire logic [SB0_SRC-1:0] sb0_flags,
	input wire logic [CONV_SRC-1:0] conv_flags,
	input wire logic [TA0_SRC-1:0] ta0_flags,
	input wire logic [NUM_VEC-1:0] maskable_enable,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_rvalid,
	output logic [15:0] mem_addr,
	output logic mem_req,
	output logic [15:0] pc_load,
	output logic pc_load_valid,
	output logic startup_done,
	output logic [SIG_WORDS*16-1:0] signatures,
	output logic boot_pw_enabled,
	output logic [4:0] debug_pw_words,
	output logic irq_req,
	output logic [15:0] irq_vec_addr,
	output logic nmi_req,
	output logic [15:0] reset_cause_vector_reg,
	output logic [15:0] system_nmi_vector_reg,
	output logic [15:0] user_nmi_vector_reg,
	output logic [15:0] comparator_vector_reg,
	output logic [15:0] timer_b0_vector_reg,
	output logic [15:0] serial_a0_vector_reg,
	output logic [15:0] serial_b0_vector_reg,
	output logic [15:0] converter_vector_reg,
	output logic [15:0] timer_a0_vector_reg
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ST_SIG, ST_VEC, ST_RUN} phase_t;
	typedef struct packed {
		phase_t phase;
		logic [2:0] idx;
		logic [15:0] addr;
		logic req;
		logic [15:0] pc;
		logic pcv;
		logic [SIG_WORDS*16-1:0] sig;
		logic [15:0] ivec;
		logic irq;
		logic nmi;
	} state_t;
	state_t s_q, s_d;

	logic [SB0_SRC-1:0] sb0_src;
	logic [SA0_SRC-1:0] sa0_src;
	logic [SNMI_SRC-1:0] snmi_src;
	logic [UNMI_SRC-1:0] unmi_src;
	logic [NUM_VEC-1:0] pend;
	logic [15:0] rsv, snv, unv, cmv, tbv, sav, sbv, cvv, tav;

	// ---------------------------------------------------------------
	// source gating per group
	// ---------------------------------------------------------------
	assign snmi_src = {uncorrectable_bit_error_flag,
		correctable_bit_error_flag, debug_mailbox_out_flag,
		debug_mailbox_in_flag, vacant_access_flag} & sys_nmi_enable;
	assign unmi_src = {oscillator_fault_flag, external_nmi_flag}
		& user_nmi_enable;
	// sync mode: only rx/tx (bits 0,1); start/complete in bits 2,3
	assign sa0_src = sa0_async_mode ? sa0_flags
		: {2'b00, sa0_flags[1:0]};
	assign sb0_src = (sb0_mode == SB0_MODE_TWO_WIRE) ? sb0_flags
		: {12'h000, sb0_flags[1:0]};

	// ---------------------------------------------------------------
	// vector generators
	// ---------------------------------------------------------------
	flag_vector_gen #(.N(RST_SRC)) u_rst (.flags(reset_cause_flags),
		.code(rsv));
	flag_vector_gen #(.N(SNMI_SRC)) u_snmi (.flags(snmi_src),
		.code(snv));
	flag_vector_gen #(.N(UNMI_SRC)) u_unmi (.flags(unmi_src),
		.code(unv));
	flag_vector_gen #(.N(CMP_SRC)) u_cmp (.flags(cmp_flags),
		.code(cmv));
	flag_vector_gen #(.N(TB0_SRC-1)) u_tb0 (.flags(tb0_flags[TB0_SRC-1:1]),
		.code(tbv));
	flag_vector_gen #(.N(SA0_SRC)) u_sa0 (.flags(sa0_src),
		.code(sav));
	flag_vector_gen #(.N(SB0_SRC)) u_sb0 (.flags(sb0_src),
		.code(sbv));
	flag_vector_gen #(.N(CONV_SRC)) u_cnv (.flags(conv_flags),
		.code(cvv));
	flag_vector_gen #(.N(TA0_SRC-1)) u_ta0 (.flags(ta0_flags[TA0_SRC-1:1]),
		.code(tav));

	// ---------------------------------------------------------------
	// pending maskable requests, index 0 is the highest address
	// ---------------------------------------------------------------
	always_comb begin
		pend = '0;
		pend[0] = |cmp_flags;
		pend[1] = tb0_flags[0];
		pend[2] = |tb0_flags[TB0_SRC-1:1];
		pend[3] = interval_timer_flag & wdt_interval_mode;
		pend[4] = |sa0_src;
		pend[5] = |sb0_src;
		pend[6] = |conv_flags;
		pend[7] = ta0_flags[0];
		pend[8] = |ta0_flags[TA0_SRC-1:1];
		pend = pend & maskable_enable;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.pcv = 1'b0;
		s_d.irq = 1'b0;
		s_d.nmi = 1'b0;
		s_d.ivec = 16'h0000;
		case (s_q.phase)
			ST_SIG: begin
				s_d.req = 1'b1;
				s_d.addr = SIG_BASE_ADDR + {12'h000, s_q.idx, 1'b0};
				if (s_q.req && mem_rvalid) begin
					s_d.sig[s_q.idx*16 +: 16] = mem_rdata;
					if (s_q.idx == 3'(SIG_WORDS - 1)) begin
						s_d.phase = ST_VEC;
						s_d.addr = RESET_VEC_ADDR;
					end else begin
						s_d.idx = s_q.idx + 3'h1;
						s_d.addr = SIG_BASE_ADDR
							+ {12'h000, s_d.idx, 1'b0};
					end
				end
			end
			ST_VEC: begin
				s_d.req = 1'b1;
				s_d.addr = RESET_VEC_ADDR;
				if (s_q.req && mem_rvalid) begin
					s_d.pc = mem_rdata;
					s_d.pcv = 1'b1;
					s_d.req = 1'b0;
					s_d.phase = ST_RUN;
				end
			end
			ST_RUN: begin
				s_d.req = 1'b0;
				// nmi ignores gie, maskable ones need it
				if (|snmi_src) begin
					s_d.nmi = 1'b1;
					s_d.ivec = SYS_NMI_VEC_ADDR;
				end else if (|unmi_src) begin
					s_d.nmi = 1'b1;
					s_d.ivec = USER_NMI_VEC_ADDR;
				end else if (gie && |pend) begin
					s_d.irq = 1'b1;
					for (int i = 8; i >= 0; i--) begin
						if (pend[i]) begin
							s_d.ivec = CMP_VEC_ADDR
								- 16'(i * 2);
						end
					end
				end
			end
			default: s_d.phase = ST_SIG;
		endcase
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '{phase: ST_SIG, idx: 3'h0, addr: SIG_BASE_ADDR,
				req: 1'b0, pc: 16'h0000, pcv: 1'b0, sig: '0,
				ivec: 16'h0000, irq: 1'b0, nmi: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign mem_addr = s_q.addr;
	assign mem_req = s_q.req;
	assign pc_load = s_q.pc;
	assign pc_load_valid = s_q.pcv;
	assign startup_done = (s_q.phase == ST_RUN);
	assign signatures = s_q.sig;
	// bootloader signature 1 is word 2
	assign boot_pw_enabled = startup_done
		&& (s_q.sig[2*16 +: 16] == ENABLED_SIG);
	// debug password from its base word up; length in debug signature 2
	assign debug_pw_words = startup_done ? s_q.sig[1*16 +: 5]
		: 5'h00;
	assign irq_req = s_q.irq;
	assign nmi_req = s_q.nmi;
	assign irq_vec_addr = s_q.ivec;
	assign reset_cause_vector_reg = rsv;
	assign system_nmi_vector_reg = snv;
	assign user_nmi_vector_reg = unv;
	assign comparator_vector_reg = cmv;
	assign timer_b0_vector_reg = tbv;
	assign serial_a0_vector_reg = sav;
	assign serial_b0_vector_reg = sbv;
	assign converter_vector_reg = cvv;
	assign timer_a0_vector_reg = tav;
endmodule
`default_nettype wire
